//--- verilog/dacsl_pkg.sv
// constants of the serial load path of a 10-bit converter
// assumes: included before every other file of the block
package dacsl_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS = 16;        // full cascade frame
  localparam int unsigned CODE_W     = 10;        // converter code width
  localparam int unsigned CODE_MSB   = 11;        // code msb inside frame
  localparam int unsigned CODE_LSB   = 2;         // code lsb inside frame
  localparam int unsigned FIFO_DEPTH = 4;         // frames buffered

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
  localparam logic [CODE_W-1:0]     CODE_RST  = 10'h000;
  localparam logic                  DOUT_RST  = 1'b0;

  typedef logic [CODE_W-1:0] dacsl_code_t;

endpackage

//--- verilog/dacsl_stream_if.sv
// valid/ready carrier for converter codes between block modules
// assumes: producer and consumer share one clock
`timescale 1ns/10ps
`default_nettype none

interface dacsl_stream_if #(
  parameter int unsigned WIDTH = 10
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  // side that offers words
  modport prod (output valid, output data, input ready);
  // side that takes words
  modport cons (input valid, input data, output ready);
endinterface

`default_nettype wire

//--- verilog/dacsl_fifo.sv
// small synchronous fifo for converter codes
// assumes: both sides on core_clk_i, depth a power of two
`timescale 1ns/10ps
`default_nettype none

module dacsl_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  dacsl_stream_if.cons   in_s,
  dacsl_stream_if.prod   out_s
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  // ****************************************
  // handshake and pointers
  // ****************************************
  assign in_s.ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data  = mem_reg[rd_ptr_reg];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // next pointer and fill level
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage needs no reset, words are only read while valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end
endmodule

`default_nettype wire

//--- verilog/dacsl_top.sv
// serial load path of a single-channel 10-bit converter with chain output
// assumes: host drives cs_n_i, sclk_i, din_i; sclk_i held low around cs_n_i edges
`timescale 1ns/10ps
`default_nettype none

module dacsl_top #(
  parameter int unsigned FIFO_DEPTH = dacsl_pkg::FIFO_DEPTH
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                din_i,
  input  wire logic                dac_ready_i,
  output logic                     dout_o,
  output dacsl_pkg::dacsl_code_t   dac_code_o,
  output logic                     dac_update_o,
  output logic                     frame_ready_o,
  output logic                     overrun_o
);
  import dacsl_pkg::*;

  // ****************************************
  // link domain: shift clock
  // ****************************************
  // link state moves only on sclk_i and cs_n_i edges, never on the core clock
  logic [FRAME_BITS-1:0] shift_reg;
  logic [FRAME_BITS-1:0] shift_next;
  logic                  dout_reg;
  logic                  dout_next;

  // a short frame of twelve bits also lands right, code sits at the same
  // offset from the end; sixteen bits are needed only for cascading
  always_comb begin
    shift_next = shift_reg;
    if (!cs_n_i) begin
      shift_next = {shift_reg[FRAME_BITS-2:0], din_i};
    end
  end

  // shift register runs on the host clock alone, reset straight from the pin
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // chain output re-emits the oldest bit half a clock after it reaches the
  // top, giving sixteen rising edges plus one falling edge of delay
  always_comb begin
    dout_next = dout_reg;
    if (!cs_n_i) begin
      dout_next = shift_reg[FRAME_BITS-1];
    end
  end

  // falling edge only, so the next device sees data stable at its rising edge
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_reg <= DOUT_RST;
    end else begin
      dout_reg <= dout_next;
    end
  end

  // no enable: the pin never floats, even with select high
  // chain output is always driven, totem pole
  assign dout_o = dout_reg;

  // ****************************************
  // frame end: rising chip select
  // ****************************************
  // the shift clock is stopped when select rises, so the end of a frame is
  // caught on the select edge itself and handed over by a toggle
  logic [FRAME_BITS-1:0] hold_reg;
  logic [FRAME_BITS-1:0] hold_next;
  logic                  frame_tgl_reg;
  logic                  frame_tgl_next;

  always_comb begin
    hold_next      = shift_reg;
    frame_tgl_next = ~frame_tgl_reg;
  end

  // clocked by select itself; a glitch on that pin would latch a frame
  always_ff @(posedge cs_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg      <= SHIFT_RST;
      frame_tgl_reg <= 1'b0;
    end else begin
      hold_reg      <= hold_next;
      frame_tgl_reg <= frame_tgl_next;
    end
  end

  // ****************************************
  // core domain: toggle crossing
  // ****************************************
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_seen_reg;
  logic tgl_meta_next;
  logic tgl_sync_next;
  logic tgl_seen_next;
  logic frame_evt;

  // first stage is read only by the second
  always_comb begin
    tgl_meta_next = frame_tgl_reg;
    tgl_sync_next = tgl_meta_reg;
    tgl_seen_next = tgl_sync_reg;
  end

  // two flops settle the toggle, the third remembers the last one seen
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= tgl_meta_next;
      tgl_sync_reg <= tgl_sync_next;
      tgl_seen_reg <= tgl_seen_next;
    end
  end

  // hold_reg is quiet here: it only moves at the next select edge, which is
  // at least a full frame away; frames closer than the sync delay are lost
  assign frame_evt = tgl_sync_reg ^ tgl_seen_reg;

  // ****************************************
  // code buffer
  // ****************************************
  // codes from the select side in, codes toward the converter out
  dacsl_stream_if #(.WIDTH(CODE_W)) fill_s ();
  dacsl_stream_if #(.WIDTH(CODE_W)) drain_s ();

  assign fill_s.valid  = frame_evt;
  assign fill_s.data   = hold_reg[CODE_MSB:CODE_LSB];
  assign drain_s.ready = dac_ready_i;

  // a few codes ride out a converter side that is slow to accept
  dacsl_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .in_s    (fill_s),
    .out_s   (drain_s)
  );

  // ****************************************
  // converter register and status
  // ****************************************
  dacsl_code_t code_reg;
  dacsl_code_t code_next;
  logic        update_reg;
  logic        update_next;
  logic        ready_reg;
  logic        ready_next;
  logic        overrun_reg;
  logic        overrun_next;

  // code moves on when the converter side accepts it; a frame arriving while
  // the buffer is full is dropped and flagged until reset
  always_comb begin
    code_next    = code_reg;
    update_next  = 1'b0;
    if (drain_s.valid && drain_s.ready) begin
      code_next   = drain_s.data;
      update_next = 1'b1;
    end
    ready_next   = fill_s.ready;
    overrun_next = overrun_reg | (frame_evt & ~fill_s.ready);
  end

  // converter register starts at zero code, as after power-up
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg    <= CODE_RST;
      update_reg  <= 1'b0;
      ready_reg   <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      code_reg    <= code_next;
      update_reg  <= update_next;
      ready_reg   <= ready_next;
      overrun_reg <= overrun_next;
    end
  end

  // every output is a flop, so the converter never sees a decode glitch;
  // the price is one core cycle of latency on each status flag
  assign dac_code_o    = code_reg;
  assign dac_update_o  = update_reg;
  assign frame_ready_o = ready_reg;
  assign overrun_o     = overrun_reg;
endmodule

`default_nettype wire

//--- bench/dacsl_monitor.sv
// checker on the top ports of the serial load path
// assumes: bound to dacsl_top; shift clock idle outside frames
`timescale 1ns/10ps
`default_nettype none
module dacsl_monitor (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   sclk_i,
  input wire logic                   cs_n_i,
  input wire logic                   din_i,
  input wire logic                   dac_ready_i,
  input wire logic                   dout_o,
  input wire dacsl_pkg::dacsl_code_t dac_code_o,
  input wire logic                   dac_update_o,
  input wire logic                   frame_ready_o,
  input wire logic                   overrun_o
);
  import dacsl_pkg::*;
  // ****
  // helpers
  // ****
  logic [4:0] rise_reg;
  logic [4:0] rise_next;
  // saturating shift count, so past() never looks behind a reset
  always_comb rise_next = (rise_reg == 5'h10 || cs_n_i) ? rise_reg : rise_reg + 5'h01;
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) rise_reg <= 5'h00;
    else rise_reg <= rise_next;
  end
  sequence s_cs_quiet;
    cs_n_i [*2];
  endsequence
  sequence s_reset_exit;
    $rose(rst_n_i);
  endsequence
  // ****
  // link domain
  // ****
  a_chain_delay: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
    (rise_reg == 5'h10 && !cs_n_i) |-> dout_o == $past(din_i, 16))
    else $error("chain delay wrong");
  // ****
  // core domain
  // ****
  a_dout_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_cs_quiet |-> $stable(dout_o)) else $error("chain output moved");
  a_code_cause: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $changed(dac_code_o) |-> dac_update_o) else $error("code moved alone");
  a_reset_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_reset_exit |-> dac_code_o == CODE_RST && dout_o == DOUT_RST && !overrun_o)
    else $error("reset values wrong");
  a_ready_up: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_reset_exit |-> ##1 frame_ready_o) else $error("not ready after reset");
  a_overrun_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    overrun_o |=> overrun_o) else $error("overrun cleared");
  a_update_handshake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dac_update_o |-> $past(dac_ready_i)) else $error("update while stalled");
  a_drop_full: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(overrun_o) |-> !frame_ready_o) else $error("drop while not full");
endmodule
bind dacsl_top dacsl_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dac_ready_i(dac_ready_i),
  .dout_o(dout_o), .dac_code_o(dac_code_o), .dac_update_o(dac_update_o),
  .frame_ready_o(frame_ready_o), .overrun_o(overrun_o));
`default_nettype wire

//--- bench/dacsl_host_model.sv
// host serial master: select, shift clock and data
// assumes: bench calls xfer; shift clock 15 ns, low outside frames
`timescale 1ns/10ps
`default_nettype none
module dacsl_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // ****
  // frame transfer
  // ****
  // low n bits msb first; a byte host calls twice, last low first
  task automatic xfer(input logic [15:0] f, input int n, input bit last);
    cs_n_o = 1'b0;
    #8;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = f[i];
      #4 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
      #3.5;
    end
    // select rises with clock low; released data shows no stale bit
    if (last) begin
      #8 cs_n_o = 1'b1;
      din_o = ~din_o;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/dacsl_top_bench.sv
// self-checking bench for the serial load path
// assumes: host model drives the link, checker bound to the top
`timescale 1ns/10ps
`default_nettype none
module dacsl_top_bench;
  import dacsl_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        dac_ready;
  wire logic   sclk;
  wire logic   cs_n;
  wire logic   din;
  logic        dout;
  logic        upd;
  logic        frdy;
  logic        ovr;
  dacsl_code_t code;
  logic        chain_dout;
  dacsl_code_t chain_code;
  logic [15:0] g;
  dacsl_code_t exp_q[$];
  logic [15:0] f;
  int          failures = 0;
  int          compares = 0;
  always #50 core_clk = ~core_clk;
  dacsl_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  dacsl_top #(.FIFO_DEPTH(FIFO_DEPTH)) u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dac_ready_i(dac_ready), .dout_o(dout),
    .dac_code_o(code), .dac_update_o(upd), .frame_ready_o(frdy), .overrun_o(ovr));
  // second device on the chain output, select and shift clock shared
  dacsl_top #(.FIFO_DEPTH(FIFO_DEPTH)) u_chain (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(dout), .dac_ready_i(dac_ready),
    .dout_o(chain_dout), .dac_code_o(chain_code), .dac_update_o(), .frame_ready_o(),
    .overrun_o());
  // ****
  // checking
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // each update takes the oldest noted code; a spare update fails
  // looked at on the falling edge, where the output flops have settled
  always @(negedge core_clk) begin
    if (upd === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check({6'h00, code}, {6'h00, exp_q.pop_front()});
    end
  end
  // random full or short frame; noted only if it should arrive
  task automatic send(input int n, input bit noted);
    f = 16'($urandom);
    if (noted) exp_q.push_back(f[11:2]);
    u_host.xfer(f, n, 1'b1);
    repeat (8) @(negedge core_clk);
    if (n == 16) check({15'h0000, dout}, {15'h0000, f[15]});
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    rst_n = 1'b0;
    dac_ready = 1'b0;
    void'($urandom(55));
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    dac_ready = 1'b1;
    repeat (4) @(negedge core_clk);
    check({6'h00, code}, 16'h0000);
    for (int k = 0; k < 6; k++) send(16, 1'b1);
    send(12, 1'b1);
    // two bytes under one select
    f = 16'($urandom);
    exp_q.push_back(f[11:2]);
    u_host.xfer({8'h00, f[15:8]}, 8, 1'b0);
    u_host.xfer(f, 8, 1'b1);
    repeat (8) @(negedge core_clk);
    // two devices chained: the far one keeps the first frame of 32 bits
    g = 16'($urandom);
    f = 16'($urandom);
    exp_q.push_back(f[11:2]);
    u_host.xfer(g, 16, 1'b0);
    u_host.xfer(f, 16, 1'b1);
    repeat (8) @(negedge core_clk);
    check({6'h00, chain_code}, {6'h00, g[11:2]});
    check({15'h0000, chain_dout}, {15'h0000, g[15]});
    // stalled converter: four queue up, the fifth is dropped
    dac_ready = 1'b0;
    for (int k = 0; k < 5; k++) send(16, k < 4);
    check({14'h0000, frdy, ovr}, 16'h0001);
    dac_ready = 1'b1;
    repeat (8) @(negedge core_clk);
    // idle converter parked at zero code
    exp_q.push_back(10'h000);
    u_host.xfer(16'h0000, 16, 1'b1);
    repeat (8) @(negedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
    // reset in mid run
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    check({4'h0, ovr, dout, code}, 16'h0000);
    wrap_up;
  end
  // cuts a hang; the run needs well under 100 us
  initial begin
    #500000;
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
